// ---- verilog/gpb_regs.vh ----
// Register indices, field layouts and reset values of the bus-multiplexed port block
`ifndef GPB_REGS_VH
`define GPB_REGS_VH

// Register index on the APB; byte address is four times the index
`define GPB_IDX_W            6
`define GPB_IDX_MODE         6'h0E
`define GPB_IDX_BANK         6'h0F
`define GPB_IDX_10           6'h10
`define GPB_IDX_11           6'h11
`define GPB_IDX_12           6'h12
`define GPB_IDX_13           6'h13

// Bank numbers selecting the banked window at indices 10h..13h
`define GPB_BANK_0           8'h00
`define GPB_BANK_1           8'h01

// Operating mode codes held in the mode register
`define GPB_MODE_W           2
`define GPB_MODE_MICROPROC   2'h0
`define GPB_MODE_EXT_MCU     2'h1
`define GPB_MODE_MCU         2'h2
`define GPB_MODE_PROT_MCU    2'h3
`define GPB_MODE_BUS_BIT     2

// Reset values
`define GPB_DIR_RESET        8'hFF
`define GPB_BANK_RESET       8'h00
`define GPB_MODE_RESET       2'h2
`define GPB_ZERO8            8'h00
`define GPB_ZERO16           16'h0000
`define GPB_ZERO32           32'h00000000

`endif

// ---- verilog/gpb_port.v ----
// One 8-bit bidirectional port: direction and output latch with system bus override
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.vh"

module gpb_port (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       dir_wr,
    input  wire       lat_wr,
    input  wire [7:0] wdata,
    input  wire       bus_active,
    input  wire [7:0] bus_out,
    input  wire [7:0] bus_oe,
    output reg  [7:0] dir,
    output reg  [7:0] lat,
    output reg  [7:0] pin_out,
    output reg  [7:0] pin_oe
);

    // Direction comes up all inputs on any reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir <= `GPB_DIR_RESET;
        end else if (dir_wr) begin
            dir <= wdata;
        end
    end

    // Latch has no reset: it keeps its prior value across a reset
    always @(posedge pclk) begin
        if (lat_wr) begin
            lat <= wdata;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i]  <= 1'b0;
                end else if (bus_active) begin
                    pin_out[i] <= bus_out[i];
                    pin_oe[i]  <= bus_oe[i];
                end else begin
                    pin_out[i] <= lat[i];
                    pin_oe[i]  <= ~dir[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- verilog/gpb_apb_slave.v ----
// APB handshake: zero-wait answer with registered ready, and the write strobe
`timescale 1ns/1ps
`default_nettype none

module gpb_apb_slave (
    input  wire pclk,
    input  wire presetn,
    input  wire psel,
    input  wire penable,
    input  wire pwrite,
    output reg  pready,
    output wire setup,
    output wire wr_en
);

    assign setup = psel & ~penable;
    // Write commits only at the edge where ready is sampled high
    assign wr_en = psel & penable & pready & pwrite;

    // Ready rises for exactly the access cycle that follows a setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/gpb_top.v ----
// Bus-multiplexed general purpose ports with banked APB register access
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.vh"

module gpb_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire [7:0]  second_port_pins_in,
    output wire [7:0]  second_port_pins_out,
    output wire [7:0]  second_port_pins_oe,
    input  wire [7:0]  low_byte_port_pins_in,
    output wire [7:0]  low_byte_port_pins_out,
    output wire [7:0]  low_byte_port_pins_oe,
    input  wire [7:0]  high_byte_port_pins_in,
    output wire [7:0]  high_byte_port_pins_out,
    output wire [7:0]  high_byte_port_pins_oe,
    input  wire [15:0] addr_data_out,
    input  wire [15:0] addr_data_oe,
    output reg  [15:0] addr_data_in,
    output reg         bus_active
);

    wire                   setup;
    wire                   wr_en;
    wire [`GPB_IDX_W-1:0]  idx;
    reg  [7:0]             bank_select_value;
    reg  [`GPB_MODE_W-1:0] mode;
    wire                   bank0;
    wire                   bank1;

    // Latches are never read back: a data register read returns the pins
    wire [7:0] second_port_direction;
    wire [7:0] low_byte_port_direction;
    wire [7:0] high_byte_port_direction;

    reg        sel_mode;
    reg        sel_bank;
    reg        sel_second_dir;
    reg        sel_second_pins;
    reg        sel_low_dir;
    reg        sel_low_pins;
    reg        sel_high_dir;
    reg        sel_high_pins;
    reg        mapped;
    reg [31:0] next_prdata;

    assign idx   = paddr[7:2];
    assign bank0 = (bank_select_value == `GPB_BANK_0);
    assign bank1 = (bank_select_value == `GPB_BANK_1);

    gpb_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pready  (pready),
        .setup   (setup),
        .wr_en   (wr_en)
    );

    // Banked decode: the port registers appear only in their own bank
    always @* begin
        sel_mode        = (idx == `GPB_IDX_MODE);
        sel_bank        = (idx == `GPB_IDX_BANK);
        sel_second_dir  = bank0 & (idx == `GPB_IDX_11);
        sel_second_pins = bank0 & (idx == `GPB_IDX_12);
        sel_low_dir     = bank1 & (idx == `GPB_IDX_10);
        sel_low_pins    = bank1 & (idx == `GPB_IDX_11);
        sel_high_dir    = bank1 & (idx == `GPB_IDX_12);
        sel_high_pins   = bank1 & (idx == `GPB_IDX_13);
        mapped = sel_mode | sel_bank | sel_second_dir | sel_second_pins |
                 sel_low_dir | sel_low_pins | sel_high_dir | sel_high_pins;
    end

    // Data register reads return the pin levels, not the latch
    always @* begin
        next_prdata = `GPB_ZERO32;
        if (sel_mode) begin
            next_prdata[`GPB_MODE_W-1:0]  = mode;
            next_prdata[`GPB_MODE_BUS_BIT] = bus_active;
        end else if (sel_bank) begin
            next_prdata[7:0] = bank_select_value;
        end else if (sel_second_dir) begin
            next_prdata[7:0] = second_port_direction;
        end else if (sel_second_pins) begin
            next_prdata[7:0] = second_port_pins_in;
        end else if (sel_low_dir) begin
            next_prdata[7:0] = low_byte_port_direction;
        end else if (sel_low_pins) begin
            next_prdata[7:0] = low_byte_port_pins_in;
        end else if (sel_high_dir) begin
            next_prdata[7:0] = high_byte_port_direction;
        end else if (sel_high_pins) begin
            next_prdata[7:0] = high_byte_port_pins_in;
        end
    end

    // Read data and error are captured in the setup cycle and stand through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `GPB_ZERO32;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? `GPB_ZERO32 : next_prdata;
            pslverr <= ~mapped;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Mode and bank registers; a write to an unmapped index changes nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode              <= `GPB_MODE_RESET;
            bank_select_value <= `GPB_BANK_RESET;
        end else if (wr_en) begin
            if (sel_mode) begin
                mode <= pwdata[`GPB_MODE_W-1:0];
            end
            if (sel_bank) begin
                bank_select_value <= pwdata[7:0];
            end
        end
    end

    // Bus duty only in the two external-memory modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_active <= 1'b0;
        end else begin
            bus_active <= (mode == `GPB_MODE_MICROPROC) | (mode == `GPB_MODE_EXT_MCU);
        end
    end

    // Pins seen by the bus engine, registered so every output comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_data_in <= `GPB_ZERO16;
        end else begin
            addr_data_in <= {high_byte_port_pins_in, low_byte_port_pins_in};
        end
    end

    // Second port never carries the system bus
    gpb_port u_second (
        .pclk       (pclk),
        .presetn    (presetn),
        .dir_wr     (wr_en & sel_second_dir),
        .lat_wr     (wr_en & sel_second_pins),
        .wdata      (pwdata[7:0]),
        .bus_active (1'b0),
        .bus_out    (`GPB_ZERO8),
        .bus_oe     (`GPB_ZERO8),
        .dir        (second_port_direction),
        .lat        (),
        .pin_out    (second_port_pins_out),
        .pin_oe     (second_port_pins_oe)
    );

    // Low byte: address/data bits 7..0 while the bus owns the pins
    gpb_port u_low (
        .pclk       (pclk),
        .presetn    (presetn),
        .dir_wr     (wr_en & sel_low_dir),
        .lat_wr     (wr_en & sel_low_pins),
        .wdata      (pwdata[7:0]),
        .bus_active (bus_active),
        .bus_out    (addr_data_out[7:0]),
        .bus_oe     (addr_data_oe[7:0]),
        .dir        (low_byte_port_direction),
        .lat        (),
        .pin_out    (low_byte_port_pins_out),
        .pin_oe     (low_byte_port_pins_oe)
    );

    // High byte: address/data bits 15..8 while the bus owns the pins
    gpb_port u_high (
        .pclk       (pclk),
        .presetn    (presetn),
        .dir_wr     (wr_en & sel_high_dir),
        .lat_wr     (wr_en & sel_high_pins),
        .wdata      (pwdata[7:0]),
        .bus_active (bus_active),
        .bus_out    (addr_data_out[15:8]),
        .bus_oe     (addr_data_oe[15:8]),
        .dir        (high_byte_port_direction),
        .lat        (),
        .pin_out    (high_byte_port_pins_out),
        .pin_oe     (high_byte_port_pins_oe)
    );

endmodule
`default_nettype wire

// ---- tb/gpb_asserts.sv ----
// Concurrent checks on the port pins and the APB answer of the port block
`timescale 1ns/1ps
`default_nettype none
module gpb_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  second_port_pins_oe,
    input wire logic [7:0]  low_byte_port_pins_out,
    input wire logic [7:0]  low_byte_port_pins_oe,
    input wire logic [7:0]  high_byte_port_pins_out,
    input wire logic [7:0]  high_byte_port_pins_oe,
    input wire logic [15:0] addr_data_out,
    input wire logic [15:0] addr_data_oe,
    input wire logic        bus_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite && pready;
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_setup; s_setup |=> s_answer; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_low_bus; bus_active && $past(bus_active) |-> low_byte_port_pins_out == $past(addr_data_out[7:0])
        && low_byte_port_pins_oe == $past(addr_data_oe[7:0]); endproperty
    property p_high_bus; bus_active && $past(bus_active) |-> high_byte_port_pins_out == $past(addr_data_out[15:8])
        && high_byte_port_pins_oe == $past(addr_data_oe[15:8]); endproperty
    // Mode is software state, so bus duty may only move after a write
    property p_mode; $changed(bus_active) |-> $past(wr) || $past(wr, 2); endproperty
    property p_sp_oe; $changed(second_port_pins_oe) |-> $past(wr, 2); endproperty
    property p_hi_oe; $changed(high_byte_port_pins_oe) && !$past(bus_active) && !$past(bus_active, 2)
        |-> $past(wr, 2); endproperty
    property p_rst; $rose(presetn) |-> second_port_pins_oe == 8'h00 && low_byte_port_pins_oe == 8'h00
        && high_byte_port_pins_oe == 8'h00; endproperty
    a_setup: assert property (p_setup) else $error("ready not one cycle after setup");
    a_err: assert property (p_err) else $error("error without ready");
    a_low_bus: assert property (p_low_bus) else $error("low pins not on bus");
    a_high_bus: assert property (p_high_bus) else $error("high pins not on bus");
    a_mode: assert property (p_mode) else $error("bus duty changed without write");
    a_sp_oe: assert property (p_sp_oe) else $error("second port enable moved alone");
    a_hi_oe: assert property (p_hi_oe) else $error("high port enable moved alone");
    a_rst: assert property (p_rst) else $error("pins driven after reset");
endmodule
bind gpb_top gpb_asserts gpb_asserts_i (.*);
`default_nettype wire

// ---- tb/gpb_pins_model.sv ----
// Far-side parties on the three ports: each pin follows the port where enabled, else the far side
`timescale 1ns/1ps
`default_nettype none
module gpb_pins_model (
    input  wire logic [7:0] pout [3],
    input  wire logic [7:0] poe  [3],
    input  wire logic [7:0] ext  [3],
    output var  logic [7:0] pin  [3]
);
    // A released pin shows the far side, so a read sees the latch only on pins driven as outputs
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin[i] = (poe[i] & pout[i]) | (~poe[i] & ext[i]);
        end
    end
endmodule
`default_nettype wire

// ---- tb/gpb_top_test.sv ----
// Self-checking bench for the bus-multiplexed ports
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.vh"
module gpb_top_test;
    logic        pclk, presetn, psel, penable, pwrite, rerr;
    wire         pready, pslverr, bus_active;
    logic [7:0]  paddr, ext [3], dirs [3], lats [3];
    logic [31:0] pwdata, rdat;
    wire  [31:0] prdata;
    logic [15:0] ad_out, ad_oe;
    wire  [15:0] ad_in;
    wire  [7:0]  pout [3], poe [3], pin [3];
    logic [1:0]  p;
    int          err_count, total_checks;
    // Per port (second, low, high): direction index, latch index, bank
    localparam logic [5:0] DIDX [3] = '{6'h11, 6'h10, 6'h12};
    localparam logic [5:0] LIDX [3] = '{6'h12, 6'h11, 6'h13};
    localparam logic [7:0] BNK [3] = '{8'h00, 8'h01, 8'h01};
    // Row: port, latch flag, value
    localparam logic [10:0] ROWS [6] = '{{2'd0, 1'b1, 8'hA5}, {2'd0, 1'b0, 8'hCF}, {2'd1, 1'b1, 8'h3C},
        {2'd1, 1'b0, 8'h00}, {2'd2, 1'b1, 8'hFF}, {2'd2, 1'b0, 8'h0F}};
    gpb_top gpb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .second_port_pins_in(pin[0]), .second_port_pins_out(pout[0]), .second_port_pins_oe(poe[0]),
        .low_byte_port_pins_in(pin[1]), .low_byte_port_pins_out(pout[1]), .low_byte_port_pins_oe(poe[1]),
        .high_byte_port_pins_in(pin[2]), .high_byte_port_pins_out(pout[2]), .high_byte_port_pins_oe(poe[2]),
        .addr_data_out(ad_out), .addr_data_oe(ad_oe), .addr_data_in(ad_in), .bus_active(bus_active));
    gpb_pins_model gpb_pins_model_i (.pout(pout), .poe(poe), .ext(ext), .pin(pin));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // A wait for ready ends when ready is sampled high; only the watchdog ends it if ready never rises
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic err);
        apb(1'b0, idx, 8'h00);
        chk(rdat, {24'h000000, exp});
        chk(rerr, err);
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        results();
    end
    initial begin
        err_count = 0;
        total_checks = 0;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        ad_out = 16'h1234;
        ad_oe = 16'hFF00;
        ext = '{8'h5A, 8'h96, 8'hC3};
        dirs = '{8'hFF, 8'hFF, 8'hFF};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({poe[0], poe[1], poe[2]}, 32'h0);
        for (int r = 0; r < 6; r++) begin
            p = ROWS[r][10:9];
            apb(1'b1, `GPB_IDX_BANK, BNK[p]);
            rd(DIDX[p], dirs[p], 1'b0);
            if (ROWS[r][8]) lats[p] = ROWS[r][7:0];
            else dirs[p] = ROWS[r][7:0];
            apb(1'b1, ROWS[r][8] ? LIDX[p] : DIDX[p], ROWS[r][7:0]);
            @(posedge pclk);
            chk(poe[p], {24'h0, ~dirs[p]});
            chk(pout[p], lats[p]);
            rd(LIDX[p], (~dirs[p] & lats[p]) | (dirs[p] & ext[p]), 1'b0);
        end
        rd(6'h00, 8'h00, 1'b1);
        apb(1'b1, `GPB_IDX_BANK, 8'h00);
        // Value differs from the stored direction, so a leaked write would show on the pins
        apb(1'b1, 6'h10, 8'hFF);
        @(posedge pclk);
        chk(rerr, 1'b1);
        chk(poe[1], {24'h0, ~dirs[1]});
        for (int m = 0; m < 4; m++) begin
            ad_out <= ad_out ^ 16'h0F0F;
            apb(1'b1, `GPB_IDX_MODE, m[7:0]);
            @(posedge pclk);
            rd(`GPB_IDX_MODE, {5'h00, m < 2, m[1:0]}, 1'b0);
            chk(bus_active, m < 2);
            if (m < 2) begin
                chk({pout[2], pout[1], poe[2], poe[1]}, {ad_out, ad_oe});
                chk(ad_in, {ad_out[15:8], ext[1]});
            end else begin
                chk({poe[2], poe[1]}, {~dirs[2], ~dirs[1]});
                chk({pout[2], pout[1]}, {lats[2], lats[1]});
            end
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(6'h11, 8'hFF, 1'b0);
        apb(1'b1, 6'h11, 8'h00);
        @(posedge pclk);
        chk({poe[0], pout[0]}, {8'hFF, lats[0]});
        results();
    end
endmodule
`default_nettype wire
